// file: logic/rcf_block.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Upper byte shows frames queued at interrupt
// - Threshold mode: interrupt when count exceeds limit
// - Monitor on: interrupt when free space suffices
// - Hash index is CRC top six bits
// - Index top two pick word, rest bit
// - Hash used only in hash-perfect mode
// - Set bit accepts multicast, clear drops
// - Accept-all or accept-multicast overrides table
// - Receive flag sets on frame, clears W1C
// - Transmit space flag marks space available
module rcf_block
  import rcf_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire rcf_reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [7:0] rxq_frame_count,
  input wire logic rxq_frame_done,
  input wire logic [15:0] txq_free_dwords,
  input wire logic [15:0] receive_queue_control,
  input wire logic [15:0] transmit_queue_control,
  input wire logic accept_all_frames,
  input wire logic accept_all_multicast,
  input wire rcf_mode_t filter_mode,
  input wire logic isr_wr,
  input wire logic [15:0] isr_wdata,
  input wire rcf_da_req_t da_req,
  output logic receive_irq_flag,
  output logic tx_space_irq_flag,
  output logic mcast_accept,
  output logic mcast_drop,
  output logic [5:0] hash_index
);

  // Register map seen by the host, byte addresses of 16-bit words:
  //   frame count and threshold, next transmit space request,
  //   then four words of multicast hash table.
  // The serial front end has already turned each host access into
  // a single-cycle wr or rd pulse with byte enables, so no bus
  // protocol lives here; this block only decodes and stores.
  //
  // Read path:
  //   The read answer is registered and appears one cycle after the
  //   rd pulse, together with a one-cycle valid pulse. The data word
  //   then holds until the next read, so a slow front end may pick it
  //   up later without a second request.
  //   Addresses outside the six words read as zero. This keeps the
  //   reserved gaps around the map harmless for a host that sweeps
  //   the whole range during bring-up.
  //
  // Write path:
  //   Byte enables are honoured per lane. The upper byte of the
  //   count word is the snapshot and is never written by the host;
  //   only the low byte, the threshold, takes write data.
  //   Writes to unmapped addresses are dropped silently.
  //
  // Receive flag:
  //   Two ways to set it, chosen by the threshold enable bit:
  //   - threshold off: each completed frame sets the flag;
  //   - threshold on: the flag sets while the queued total is
  //     strictly above the programmed limit.
  //   In threshold mode the source is a level, so a clear from the
  //   host does not stick while the queue stays above the limit.
  //   That is deliberate: the host must drain frames, not just ack.
  //
  // Count snapshot:
  //   The queued total is captured when the flag rises, or when it
  //   re-rises in the same cycle as a clear. The host reads the
  //   count first and then walks the per-frame header registers; a
  //   live count would move under it as new frames arrive.
  //
  // Transmit space flag:
  //   With the monitor bit on, the flag sets whenever free memory
  //   in dwords meets or beats the host's request. The comparison
  //   is inclusive: exactly enough space is enough.
  //   Like the receive flag, the source is a level and wins over a
  //   same-cycle clear; the host should drop the monitor bit or
  //   raise the request before clearing.
  //
  // Hash filter:
  //   A destination arrives as one valid pulse with the 48-bit
  //   address. The CRC is computed combinationally in one cycle,
  //   which costs a deep xor tree but avoids a multi-cycle engine
  //   and keeps the answer latency fixed at one clock.
  //   Only group addresses are judged; unicast is left to the
  //   perfect-match logic elsewhere and gives no pulse here.
  //   The override bits accept every group frame; otherwise the
  //   table is consulted only in hash-perfect mode. In other modes
  //   neither pulse fires and the decision belongs elsewhere.
  //
  // Limitations:
  //   - One lookup per cycle; a second valid in the next cycle is
  //     fine, but results are pulses and must be taken at once.
  //   - The index of the last group lookup is kept for debug.
  //   - No interrupt enable masking here; the status block above
  //     combines these flags with its own enables.
  //
  // Timing summary:
  //   c0 rd pulse           -> c1 rdata and rvalid
  //   c0 frame done         -> c1 receive flag, snapshot loaded
  //   c0 clear, no event    -> c1 flag low
  //   c0 lookup valid       -> c1 accept or drop pulse

  // CRC-32 over the address, LSB of each octet first as on the wire
  function automatic logic [31:0] rcf_crc48(input logic [47:0] da);
    logic [31:0] c;
    logic fb;
    c = RCF_CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      fb = c[31] ^ da[i];
      c = {c[30:0], 1'b0};
      if (fb) begin
        c = c ^ RCF_CRC_POLY;
      end
    end
    return c;
  endfunction

  // Byte-lane merge for 16-bit writes
  function automatic logic [15:0] rcf_merge(input logic [15:0] old, input rcf_reg_req_t r);
    logic [15:0] m;
    m = old;
    if (r.be[0]) begin
      m[7:0] = r.wdata[7:0];
    end
    if (r.be[1]) begin
      m[15:8] = r.wdata[15:8];
    end
    return m;
  endfunction

  // Table lookup: top two index bits pick the word, low four the bit
  function automatic logic rcf_hash_bit(input logic [15:0] tbl [4], input logic [5:0] i);
    return tbl[i[5:4]][i[3:0]];
  endfunction

  logic [7:0] limit_r, limit_nxt;
  logic [7:0] total_r, total_nxt;
  logic [15:0] space_r, space_nxt;
  logic [15:0] hash_r [4];
  logic [15:0] hash_nxt [4];
  logic rx_flag_r, rx_flag_nxt;
  logic tx_flag_r, tx_flag_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic acc_r, acc_nxt;
  logic drop_r, drop_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic thr_en, rx_event, tx_event, rx_clr, tx_clr;
  logic [31:0] crc;
  logic [5:0] idx;
  logic is_mcast;
  logic hash_hit;

  // Interrupt sources
  assign thr_en = receive_queue_control[RCF_RXQ_THR_EN_BIT];
  assign rx_event = thr_en ? (rxq_frame_count > limit_r) : rxq_frame_done;
  assign tx_event = transmit_queue_control[RCF_TXQ_MON_BIT]
                    && (txq_free_dwords >= space_r);
  assign rx_clr = isr_wr && isr_wdata[RCF_ISR_RX_BIT];
  assign tx_clr = isr_wr && isr_wdata[RCF_ISR_TXSPACE_BIT];

  // Flags: a fresh event wins over a same-cycle write-one clear
  always_comb begin
    rx_flag_nxt = rx_flag_r;
    tx_flag_nxt = tx_flag_r;
    total_nxt = total_r;
    if (rx_clr) begin
      rx_flag_nxt = 1'b0;
    end
    if (rx_event) begin
      rx_flag_nxt = 1'b1;
    end
    // Count snapshot taken when the interrupt rises, so the host
    // sees a stable total while it walks the header registers
    if (rx_event && (!rx_flag_r || rx_clr)) begin
      total_nxt = rxq_frame_count;
    end
    if (tx_clr) begin
      tx_flag_nxt = 1'b0;
    end
    if (tx_event) begin
      tx_flag_nxt = 1'b1;
    end
  end

  // Register writes and reads
  always_comb begin
    limit_nxt = limit_r;
    space_nxt = space_r;
    for (int k = 0; k < 4; k++) begin
      hash_nxt[k] = hash_r[k];
    end
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_req.rd;
    if (reg_req.wr) begin
      case (reg_req.addr)
        RCF_OFS_RX_FRAME_COUNT_THRESHOLD: begin
          if (reg_req.be[0]) begin
            limit_nxt = reg_req.wdata[7:0]; // Upper byte is read-only
          end
        end
        RCF_OFS_TX_NEXT_SPACE_REQUEST: space_nxt = rcf_merge(space_r, reg_req);
        RCF_OFS_MULTICAST_HASH_WORD0: hash_nxt[0] = rcf_merge(hash_r[0], reg_req);
        RCF_OFS_MULTICAST_HASH_WORD1: hash_nxt[1] = rcf_merge(hash_r[1], reg_req);
        RCF_OFS_MULTICAST_HASH_WORD2: hash_nxt[2] = rcf_merge(hash_r[2], reg_req);
        RCF_OFS_MULTICAST_HASH_WORD3: hash_nxt[3] = rcf_merge(hash_r[3], reg_req);
        default: ; // Reserved space ignores writes
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        RCF_OFS_RX_FRAME_COUNT_THRESHOLD: rdata_nxt = {total_r, limit_r};
        RCF_OFS_TX_NEXT_SPACE_REQUEST: rdata_nxt = space_r;
        RCF_OFS_MULTICAST_HASH_WORD0: rdata_nxt = hash_r[0];
        RCF_OFS_MULTICAST_HASH_WORD1: rdata_nxt = hash_r[1];
        RCF_OFS_MULTICAST_HASH_WORD2: rdata_nxt = hash_r[2];
        RCF_OFS_MULTICAST_HASH_WORD3: rdata_nxt = hash_r[3];
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Hash filter, one frame per valid pulse, answer next cycle
  assign crc = rcf_crc48(da_req.da);
  assign idx = crc[31:26];
  assign is_mcast = da_req.da[0]; // Group bit is first bit on the wire
  assign hash_hit = rcf_hash_bit(hash_r, idx);
  always_comb begin
    acc_nxt = 1'b0;
    drop_nxt = 1'b0;
    idx_nxt = idx_r;
    if (da_req.valid && is_mcast) begin
      idx_nxt = idx;
      if (accept_all_frames || accept_all_multicast) begin
        acc_nxt = 1'b1;
      end else if (filter_mode == RCF_MODE_HASH_PERFECT) begin
        acc_nxt = hash_hit;
        drop_nxt = !hash_hit;
      end
    end
  end

  // State registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      limit_r <= RCF_LIMIT_RST;
      total_r <= RCF_LIMIT_RST;
      space_r <= RCF_SPACE_RST;
      for (int k = 0; k < 4; k++) begin
        hash_r[k] <= RCF_HASH_RST;
      end
      rx_flag_r <= 1'b0;
      tx_flag_r <= 1'b0;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
      acc_r <= 1'b0;
      drop_r <= 1'b0;
      idx_r <= 6'h00;
    end else begin
      limit_r <= limit_nxt;
      total_r <= total_nxt;
      space_r <= space_nxt;
      for (int k = 0; k < 4; k++) begin
        hash_r[k] <= hash_nxt[k];
      end
      rx_flag_r <= rx_flag_nxt;
      tx_flag_r <= tx_flag_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      acc_r <= acc_nxt;
      drop_r <= drop_nxt;
      idx_r <= idx_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign receive_irq_flag = rx_flag_r;
  assign tx_space_irq_flag = tx_flag_r;
  assign mcast_accept = acc_r;
  assign mcast_drop = drop_r;
  assign hash_index = idx_r;

endmodule // rcf_block
`default_nettype wire

// file: logic/rcf_pkg.sv
package rcf_pkg;
  // Register offsets (byte addresses of the 16-bit registers)
  localparam logic [7:0] RCF_OFS_RX_FRAME_COUNT_THRESHOLD = 8'h9C;
  localparam logic [7:0] RCF_OFS_TX_NEXT_SPACE_REQUEST = 8'h9E;
  localparam logic [7:0] RCF_OFS_MULTICAST_HASH_WORD0 = 8'hA0;
  localparam logic [7:0] RCF_OFS_MULTICAST_HASH_WORD1 = 8'hA2;
  localparam logic [7:0] RCF_OFS_MULTICAST_HASH_WORD2 = 8'hA4;
  localparam logic [7:0] RCF_OFS_MULTICAST_HASH_WORD3 = 8'hA6;
  localparam logic [7:0] RCF_OFS_RSVD_LO = 8'h94;
  localparam logic [7:0] RCF_OFS_RSVD_HI = 8'hAF;
  // Field positions
  localparam int RCF_FC_TOTAL_LSB = 8;
  localparam int RCF_RXQ_THR_EN_BIT = 5;
  localparam int RCF_TXQ_MON_BIT = 1;
  localparam int RCF_ISR_RX_BIT = 13;
  localparam int RCF_ISR_TXSPACE_BIT = 6;
  // Reset values
  localparam logic [7:0] RCF_LIMIT_RST = 8'h00;
  localparam logic [15:0] RCF_SPACE_RST = 16'h0000;
  localparam logic [15:0] RCF_HASH_RST = 16'h0000;
  // CRC-32 for the destination address hash
  localparam logic [31:0] RCF_CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] RCF_CRC_INIT = 32'hFFFFFFFF;

  // Host register access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } rcf_reg_req_t;

  // One received frame's destination for filtering
  typedef struct packed {
    logic valid;
    logic [47:0] da;
  } rcf_da_req_t;

  // Hash filtering scheme as selected elsewhere
  typedef enum logic [1:0] {
    RCF_MODE_PERFECT = 2'b00,
    RCF_MODE_HASH_PERFECT = 2'b01,
    RCF_MODE_OTHER = 2'b10
  } rcf_mode_t;
endpackage

// file: testbench/rcf_block_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rcf_block_checker
  import rcf_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire rcf_reg_req_t reg_req,
  input wire logic reg_rvalid,
  input wire logic rxq_frame_done,
  input wire logic [15:0] receive_queue_control,
  input wire logic accept_all_frames,
  input wire logic accept_all_multicast,
  input wire rcf_mode_t filter_mode,
  input wire logic isr_wr,
  input wire logic [15:0] isr_wdata,
  input wire rcf_da_req_t da_req,
  input wire logic receive_irq_flag,
  input wire logic tx_space_irq_flag,
  input wire logic mcast_accept,
  input wire logic mcast_drop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Shorthand; threshold mode is excluded where the count, not the pulse, sets the flag
  logic mc, aa, thr;
  assign mc = da_req.valid && da_req.da[0];
  assign aa = accept_all_frames || accept_all_multicast;
  assign thr = receive_queue_control[5];
  // Register answers and status flags
  AST_RD: assert property (reg_req.rd |=> reg_rvalid) else $error("read unanswered");
  AST_NO_RD: assert property (!reg_req.rd |=> !reg_rvalid) else $error("stray answer");
  AST_RX_SET: assert property (rxq_frame_done && !thr |=> receive_irq_flag)
    else $error("rx flag not set");
  AST_RX_CLR: assert property (isr_wr && isr_wdata[13] && !rxq_frame_done && !thr
    |=> !receive_irq_flag) else $error("rx flag not cleared");
  AST_TX_HOLD: assert property (tx_space_irq_flag && !(isr_wr && isr_wdata[6])
    |=> tx_space_irq_flag) else $error("tx flag lost");
  // Filter decisions one cycle after the lookup
  AST_ALL: assert property (mc && aa |=> mcast_accept && !mcast_drop)
    else $error("override ignored");
  AST_NOHASH: assert property (mc && !aa && filter_mode != RCF_MODE_HASH_PERFECT
    |=> !mcast_accept && !mcast_drop) else $error("hash outside mode");
  AST_HASH: assert property (mc && !aa && filter_mode == RCF_MODE_HASH_PERFECT
    |=> mcast_accept != mcast_drop) else $error("no hash decision");
  AST_QUIET: assert property (!mc |=> !mcast_accept && !mcast_drop)
    else $error("decision without lookup");
  cover property (mc && !aa ##1 mcast_drop);
  cover property ($rose(receive_irq_flag));
  cover property ($rose(tx_space_irq_flag));
endmodule // rcf_block_checker
bind rcf_block rcf_block_checker chk (.*);
`default_nettype wire

// file: testbench/rcf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcf_host_model
  import rcf_pkg::*;
(
  input wire logic clk,
  output var rcf_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial reg_req = '0;
  // Write is taken at the one edge it is held for
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) reg_req <= {1'b1, 1'b0, a, 2'b11, d};
    @(posedge clk) reg_req <= '0;
  endtask
  // A missing answer returns unknown so the caller's compare fails
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk) reg_req <= {1'b0, 1'b1, a, 2'b11, 16'h0000};
    @(posedge clk) reg_req <= '0;
    @(posedge clk) d = reg_rvalid ? reg_rdata : 'x;
  endtask
endmodule // rcf_host_model
`default_nettype wire

// file: testbench/rcf_block_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rcf_block_tb import rcf_pkg::*;;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic fdone = 1'b0, isr_wr = 1'b0, aaf = 1'b0, aam = 1'b0, rvalid, rxf, txf, acc, drp, f1, f2;
  logic [7:0] cnt = 8'h00;
  logic [15:0] free = 16'h0000, rqc = 16'h0000, tqc = 16'h0000, isr_d = 16'h0000, rdata;
  logic [15:0] ht [4];
  logic [47:0] dv;
  logic [5:0] hidx, ei;
  logic [1:0] ev;
  rcf_mode_t mode = RCF_MODE_HASH_PERFECT, mv;
  rcf_da_req_t da = '0;
  rcf_reg_req_t req;
  integer seed = 32'hC4ECAF08;
  int num_errors = 0, n_checks = 0;
  always #5 clk = ~clk;
  rcf_block uut (.clk(clk), .arst_n(arst_n), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .rxq_frame_count(cnt), .rxq_frame_done(fdone), .txq_free_dwords(free),
    .receive_queue_control(rqc), .transmit_queue_control(tqc), .accept_all_frames(aaf),
    .accept_all_multicast(aam), .filter_mode(mode), .isr_wr(isr_wr), .isr_wdata(isr_d),
    .da_req(da), .receive_irq_flag(rxf), .tx_space_irq_flag(txf), .mcast_accept(acc),
    .mcast_drop(drp), .hash_index(hidx));
  rcf_host_model h (.clk(clk), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid));
  // Bitwise CRC over the address, first wire bit first
  function automatic logic [5:0] hash_of(input logic [47:0] a);
    logic [31:0] c;
    c = RCF_CRC_INIT;
    for (int i = 0; i < 48; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i]) ? RCF_CRC_POLY : '0);
    return c[31:26];
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    h.rd(a, d);
    chk(d, e);
  endtask
  // Write-one-clear pulse, then one edge for the flag to settle
  task automatic clr(input logic [15:0] m);
    @(posedge clk);
    isr_wr <= 1'b1;
    isr_d <= m;
    @(posedge clk);
    isr_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic test_done();
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values, reserved holes and the read-only count byte
    for (int i = 0; i < 6; i++) rchk(8'h9C + 8'(2 * i), 16'h0000);
    h.wr(RCF_OFS_RSVD_LO, 16'hFFFF);
    rchk(RCF_OFS_RSVD_LO, 16'h0000);
    h.wr(8'hA8, 16'hFFFF);
    rchk(8'hA8, 16'h0000);
    h.wr(8'h9C, 16'hFFFF);
    rchk(8'h9C, 16'h00FF);
    for (int i = 0; i < 4; i++) begin
      ht[i] = 16'($random(seed));
      h.wr(RCF_OFS_MULTICAST_HASH_WORD0 + 8'(2 * i), ht[i]);
      rchk(RCF_OFS_MULTICAST_HASH_WORD0 + 8'(2 * i), ht[i]);
    end
    // Queued frame: flag, count snapshot read first, then clear
    @(posedge clk);
    cnt <= 8'h03;
    fdone <= 1'b1;
    @(posedge clk);
    fdone <= 1'b0;
    @(posedge clk);
    chk(16'(rxf), 16'h0001);
    rchk(8'h9C, 16'h03FF);
    clr(16'h2000);
    chk(16'(rxf), 16'h0000);
    // Threshold: equal count stays quiet, one more fires
    h.wr(8'h9C, 16'h0004);
    rqc <= 16'h0020;
    cnt <= 8'h04;
    repeat (3) @(posedge clk);
    chk(16'(rxf), 16'h0000);
    cnt <= 8'h05;
    repeat (2) @(posedge clk);
    chk(16'(rxf), 16'h0001);
    rchk(8'h9C, 16'h0504);
    rqc <= 16'h0000;
    clr(16'h2000);
    chk(16'(rxf), 16'h0000);
    // Transmit space: one dword short stays quiet, exact amount fires
    h.wr(8'h9E, 16'h0064);
    rchk(8'h9E, 16'h0064);
    free <= 16'h0063;
    tqc <= 16'h0002;
    repeat (3) @(posedge clk);
    chk(16'(txf), 16'h0000);
    free <= 16'h0064;
    repeat (2) @(posedge clk);
    chk(16'(txf), 16'h0001);
    tqc <= 16'h0000;
    clr(16'h0040);
    chk(16'(txf), 16'h0000);
    // Random multicast lookups over modes and overrides
    for (int n = 0; n < 80; n++) begin
      dv = 48'({$random(seed), $random(seed)}) | 48'(n % 7 != 0);
      f1 = ($random(seed) % 8) == 0;
      f2 = ($random(seed) % 8) == 0;
      mv = (n % 5 == 0) ? RCF_MODE_PERFECT : (n % 5 == 1) ? RCF_MODE_OTHER : RCF_MODE_HASH_PERFECT;
      ei = hash_of(dv);
      ev = !dv[0] ? 2'b00 : (f1 | f2) ? 2'b10 : (mv != RCF_MODE_HASH_PERFECT) ? 2'b00 :
        ht[ei[5:4]][ei[3:0]] ? 2'b10 : 2'b01;
      @(posedge clk);
      da <= {1'b1, dv};
      aaf <= f1;
      aam <= f2;
      mode <= mv;
      @(posedge clk);
      da.valid <= 1'b0;
      @(posedge clk);
      chk(16'({acc, drp}), 16'(ev));
      if (ev != 2'b00 && !(f1 | f2)) chk(16'(hidx), 16'(ei));
    end
    test_done();
  end
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule // rcf_block_tb
`default_nettype wire
